/* bench/sic_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none

// CPU side: finishes one instruction per clocked cycle, acks a take late or early
module sic_cpu_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // From the block
  input  wire logic       cpu_clk_en,
  input  wire logic       irq_take,
  // Ack latency in cycles
  input  wire logic [3:0] ack_delay,
  // To the block
  output logic            instr_done,
  output logic            irq_ack
);
  logic [4:0] cnt;

  // Instruction ends follow the CPU clock enable one cycle late, so one still ends in the first gated cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      instr_done <= 1'b0;
    end else begin
      instr_done <= cpu_clk_en;
    end
  end

  // Single ack pulse once the take has stood for ack_delay cycles
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt     <= 5'h00;
      irq_ack <= 1'b0;
    end else begin
      cnt     <= irq_take ? cnt + 5'h01 : 5'h00;
      irq_ack <= irq_take && !irq_ack && (cnt == {1'b0, ack_delay});
    end
  end
endmodule : sic_cpu_model

`default_nettype wire

/* bench/system_integration_int_break_lowpower_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module system_integration_int_break_lowpower_tb;
  logic clk = 1'b0, resetn = 1'b0, osc_tick = 1'b1, cpu_imask = 1'b0;
  logic swi_exec = 1'b0, wait_exec = 1'b0, stop_exec = 1'b0, break_req = 1'b0;
  logic short_recovery_select = 1'b0, watchdog_disable = 1'b0, osc_half = 1'b0;
  logic [16:1] irq_req = 16'h0000;
  logic [3:0] ack_delay = 4'h1;
  sic_pkg::sic_bus_req_t bus_req = '0;
  sic_pkg::sic_reset_causes_t reset_causes = '0;
  logic [7:0] bus_rdata, rdv;
  logic [4:0] irq_vector;
  logic irq_take, clear_imask, cpu_clk_en, periph_clk_en, osc_gate_en;
  logic watchdog_run, break_protect, in_break, instr_done, irq_ack;
  int fail_count = 0, num_checks = 0;

  always #2.5 clk = ~clk;

  // Oscillator enable: every cycle, or every other cycle to show ticks are counted
  always @(posedge clk) osc_tick <= osc_half ? !osc_tick : 1'b1;

  sic_core sic_core_i (.clk(clk), .resetn(resetn), .osc_tick(osc_tick), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .instr_done(instr_done), .cpu_imask(cpu_imask),
    .swi_exec(swi_exec), .wait_exec(wait_exec), .stop_exec(stop_exec), .irq_ack(irq_ack),
    .irq_req(irq_req), .break_req(break_req), .reset_causes(reset_causes),
    .short_recovery_select(short_recovery_select), .watchdog_disable(watchdog_disable),
    .irq_vector(irq_vector), .irq_take(irq_take), .clear_imask(clear_imask),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_gate_en(osc_gate_en),
    .watchdog_run(watchdog_run), .break_protect(break_protect), .in_break(in_break));

  sic_cpu_model sic_cpu_model_i (.clk(clk), .resetn(resetn), .cpu_clk_en(cpu_clk_en),
    .irq_take(irq_take), .ack_delay(ack_delay), .instr_done(instr_done), .irq_ack(irq_ack));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic acc(input logic rd, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= {rd, ~rd, a, d};
    @(posedge clk);
    bus_req <= '0;
    #1 rdv = bus_rdata;
  endtask : acc

  task automatic exec_low_power(input logic stop);
    @(posedge clk);
    wait_exec <= !stop;
    stop_exec <= stop;
    @(posedge clk);
    wait_exec <= 1'b0;
    stop_exec <= 1'b0;
    #1;
  endtask : exec_low_power

  // Bounded wait for a take, then its vector
  task automatic take(input logic [4:0] v);
    int c;
    c = 0;
    while (irq_take !== 1'b1 && c < 60) begin
      @(posedge clk);
      #1 c++;
    end
    chk({3'h0, irq_vector}, {3'h0, v});
  endtask : take

  task automatic idle();
    int c;
    c = 0;
    while (irq_take !== 1'b0 && c < 60) begin
      @(posedge clk);
      #1 c++;
    end
    chk({7'h0, irq_take}, 8'h00);
  endtask : idle

  task automatic t_reset_flags();
    acc(1, 16'hfe01, 0); chk(rdv, 8'h80);
    acc(1, 16'hfe01, 0); chk(rdv, 8'h00);
    acc(1, 16'hfe03, 0); chk(rdv, 8'h00);
    acc(1, 16'hfe02, 0); chk(rdv, 8'h00);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) reset_causes <= sic_pkg::sic_reset_causes_t'(7'(1 << i));
      @(posedge clk) reset_causes <= '0;
      acc(1, 16'hfe01, 0); chk(rdv, 8'(2 << i));
    end
    @(posedge clk) reset_causes <= 7'h20;
    @(posedge clk) reset_causes <= 7'h10;
    @(posedge clk) reset_causes <= '0;
    acc(1, 16'hfe01, 0); chk(rdv, 8'h60);
    @(posedge clk) reset_causes <= 7'h20;
    @(posedge clk) reset_causes <= 7'h40;
    @(posedge clk) reset_causes <= '0;
    acc(1, 16'hfe01, 0); chk(rdv, 8'h80);
  endtask : t_reset_flags

  task automatic t_status();
    logic [16:1] v;
    v = 16'hb5c3;
    @(posedge clk) cpu_imask <= 1'b1;
    irq_req <= v;
    acc(1, 16'hfe04, 0); chk(rdv, {v[6:1], 2'b00});
    acc(1, 16'hfe05, 0); chk(rdv, v[14:7]);
    acc(1, 16'hfe06, 0); chk(rdv, {6'h00, v[16:15]});
    acc(0, 16'hfe05, 8'hff); acc(1, 16'hfe05, 0); chk(rdv, v[14:7]);
    repeat (4) @(posedge clk);
    #1 chk({7'h0, irq_take}, 8'h00);
    @(posedge clk) irq_req <= 16'h0000;
    cpu_imask <= 1'b0;
  endtask : t_status

  task automatic t_priority();
    @(posedge clk) irq_req <= 16'h8001;
    take(5'd1);
    irq_req <= 16'h0104;
    idle();
    take(5'd3);
    irq_req <= 16'h0100;
    idle();
    take(5'd9);
    ack_delay <= 4'h6;
    irq_req <= 16'hc000;
    idle();
    take(5'd15);
    irq_req <= 16'h8000;
    idle();
    take(5'd16);
    irq_req <= 16'h0000;
    idle();
    @(posedge clk) irq_req <= 16'h0001;
    swi_exec <= 1'b1;
    @(posedge clk) swi_exec <= 1'b0;
    take(5'h1f);
    irq_req <= 16'h0000;
    idle();
    ack_delay <= 4'h1;
  endtask : t_priority

  task automatic t_break();
    @(posedge clk) break_req <= 1'b1;
    take(5'h1f);
    chk({6'h0, in_break, break_protect}, 8'h03);
    acc(0, 16'hfe03, 8'h80); acc(1, 16'hfe03, 0); chk(rdv, 8'h80);
    chk({7'h0, break_protect}, 8'h00);
    acc(0, 16'hfe03, 8'h00);
    @(posedge clk) break_req <= 1'b0;
    idle();
    repeat (2) @(posedge clk);
    #1 chk({6'h0, in_break, break_protect}, 8'h00);
  endtask : t_break

  task automatic t_wait();
    exec_low_power(1'b0);
    chk({4'h0, clear_imask, cpu_clk_en, periph_clk_en, watchdog_run}, 8'h0b);
    repeat (3) @(posedge clk);
    irq_req <= 16'h0010;
    take(5'd5);
    chk({7'h0, cpu_clk_en}, 8'h01);
    irq_req <= 16'h0000;
    idle();
    watchdog_disable <= 1'b1;
    exec_low_power(1'b0);
    chk({7'h0, watchdog_run}, 8'h00);
    watchdog_disable <= 1'b0;
    @(posedge clk) break_req <= 1'b1;
    take(5'h1f);
    break_req <= 1'b0;
    idle();
    acc(1, 16'hfe00, 0); chk(rdv, 8'h02);
    acc(0, 16'hfe00, 8'h00); acc(1, 16'hfe00, 0); chk(rdv, 8'h00);
  endtask : t_wait

  task automatic t_stop(input logic sr, input logic half, input int n);
    int c;
    int m;
    m = half ? 2 * n : n;
    @(posedge clk) short_recovery_select <= sr;
    osc_half <= half;
    exec_low_power(1'b1);
    chk({4'h0, osc_gate_en, periph_clk_en, cpu_clk_en, clear_imask}, 8'h01);
    repeat (5) @(posedge clk);
    irq_req <= 16'h0002;
    c = 0;
    while (irq_take !== 1'b1 && c < 5000) begin
      @(posedge clk);
      #1 c++;
    end
    chk({7'h0, c >= m && c <= m + 4}, 8'h01);
    chk({irq_vector, osc_gate_en, periph_clk_en, cpu_clk_en}, {5'd2, 3'h7});
    irq_req <= 16'h0000;
    idle();
    // A reset cause must also end stop, with no recovery wait
    exec_low_power(1'b1);
    @(posedge clk) reset_causes <= 7'h20;
    @(posedge clk) reset_causes <= '0;
    @(posedge clk);
    #1 chk({5'h0, osc_gate_en, periph_clk_en, cpu_clk_en}, 8'h07);
    acc(1, 16'hfe01, 0); chk(rdv, 8'h40);
    osc_half <= 1'b0;
  endtask : t_stop

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_reset_flags();
    t_status();
    t_priority();
    t_break();
    t_wait();
    t_stop(1'b1, 1'b1, sic_pkg::STOP_RECOVERY_SHORT);
    t_stop(1'b0, 1'b0, sic_pkg::STOP_RECOVERY_LONG);
    report_and_stop();
  end
endmodule : system_integration_int_break_lowpower_tb

`default_nettype wire

/* verilog/sic_core.sv */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Fixed priority: reset, software interrupt, then flags 1 through 16 lowest.
// - First status register shows flags 6..1 in bits 7..2, low bits zero.
// - Second status register shows flags 14..7 across all eight bits.
// - Third status register: bits 7..6 zero, flags 16 and 15 low bits.
// - All resets share top priority with no arbitration between them.
// - Break request forces CPU to the software interrupt vector.
// - In break, peripheral flag clearing is blocked unless clear enable is 1.
// - A flag cleared during break stays cleared after break ends.
// - Two-step clears stay blocked in break; second step after exit clears.
// - Wait or stop clears the CPU interrupt mask and stops CPU clock.
// - Wait: CPU clock stops, peripherals run; interrupt wakes, stacking next cycle.
// - Wait also ends on reset or break; break sets break-exited-wait flag.
// - Watchdog keeps running in wait when its disable bit is 0.
// - Stop clears stabilisation counter, gates both clocks; interrupt or reset exits.
// - Stop recovery lasts 4096 oscillator cycles, or 32 with short recovery.
// - Counter held clear in stop, times recovery; stacking only afterwards.
// - Break status at fe00, reset cause at fe01, break flag control at fe03.
// - Break-exited-wait flag reads 1 when a break ended wait mode.
// - Reading the reset cause register clears all its flags afterwards.
// - Power-on sets only its flag; other causes add their own flag.
// - Separate flags for pin, watchdog, bad opcode, bad fetch, low supply.
// - Monitor-entry flag set by the monitor-entry reset cause.
// - Stabilisation counter is 12 bits, free-running on the oscillator enable.
module sic_core (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       resetn,
  input  wire logic                       osc_tick,
  // CPU register access
  input  wire sic_pkg::sic_bus_req_t      bus_req,
  output logic [7:0]                      bus_rdata,
  // CPU events
  input  wire logic                       instr_done,
  input  wire logic                       cpu_imask,
  input  wire logic                       swi_exec,
  input  wire logic                       wait_exec,
  input  wire logic                       stop_exec,
  input  wire logic                       irq_ack,
  // Sources
  input  wire logic [16:1]                irq_req,
  input  wire logic                       break_req,
  input  wire sic_pkg::sic_reset_causes_t reset_causes,
  // Configuration
  input  wire logic                       short_recovery_select,
  input  wire logic                       watchdog_disable,
  // Outputs to CPU and system
  output logic [4:0]                      irq_vector,
  output logic                            irq_take,
  output logic                            clear_imask,
  output logic                            cpu_clk_en,
  output logic                            periph_clk_en,
  output logic                            osc_gate_en,
  output logic                            watchdog_run,
  output logic                            break_protect,
  output logic                            in_break
);

  sic_pkg::sic_mode_t mode;
  sic_pkg::sic_mode_t next_mode;
  logic [7:0]  reset_cause_status;
  logic        break_clear_enable;
  logic        break_exited_wait_flag;
  logic [11:0] stab_count;
  logic [4:0]  next_vector;
  logic        any_irq;
  logic        any_reset;
  logic        recover_done;
  logic        wake_any;

  assign any_reset = |reset_causes;
  assign any_irq   = |irq_req;

  // Lowest flag number wins, so scan from 16 down and let 1 overwrite last
  always_comb begin
    next_vector = sic_pkg::VEC_NONE;
    for (int i = sic_pkg::NUM_SOURCES; i >= 1; i--) begin
      if (irq_req[i]) begin
        next_vector = 5'(i);
      end
    end
    if (swi_exec || break_req) begin
      next_vector = sic_pkg::VEC_SWI;
    end
  end

  assign recover_done = short_recovery_select ? (stab_count == sic_pkg::STAB_SHORT_LAST)
                                              : (stab_count == sic_pkg::STAB_LONG_LAST);
  assign wake_any = any_irq || break_req;

  always_comb begin
    next_mode = mode;
    case (mode)
      sic_pkg::SIC_RUN: begin
        if (stop_exec) begin
          next_mode = sic_pkg::SIC_STOP;
        end else if (wait_exec) begin
          next_mode = sic_pkg::SIC_WAIT;
        end
      end
      sic_pkg::SIC_WAIT: begin
        if (wake_any) begin
          next_mode = sic_pkg::SIC_RUN;
        end
      end
      sic_pkg::SIC_STOP: begin
        if (wake_any) begin
          next_mode = sic_pkg::SIC_RECOVER;
        end
      end
      sic_pkg::SIC_RECOVER: begin
        if (osc_tick && recover_done) begin
          next_mode = sic_pkg::SIC_RUN;
        end
      end
      default: next_mode = sic_pkg::SIC_RUN;
    endcase
  end

  // Every reset cause acts alike and at once; none is ranked above another
  always_ff @(posedge clk) begin
    if (!resetn || any_reset) begin
      mode <= sic_pkg::SIC_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // Counter free-runs, is cleared in stop, then times recovery
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stab_count <= 12'h000;
    end else if (mode == sic_pkg::SIC_STOP || (mode == sic_pkg::SIC_RUN && stop_exec)) begin
      stab_count <= 12'h000;
    end else if (osc_tick) begin
      stab_count <= stab_count + 12'h001;
    end
  end

  // Interrupt hand-off: latched at instruction end, after wake or recovery
  always_ff @(posedge clk) begin
    if (!resetn || any_reset) begin
      irq_take   <= 1'b0;
      irq_vector <= sic_pkg::VEC_NONE;
    end else if (irq_take) begin
      if (irq_ack) begin
        irq_take <= 1'b0;
      end
    end else if (mode == sic_pkg::SIC_RUN && instr_done
                 && (swi_exec || break_req || (any_irq && !cpu_imask))) begin
      irq_take   <= 1'b1;
      irq_vector <= next_vector;
    end else if ((mode == sic_pkg::SIC_WAIT && wake_any)
                 || (mode == sic_pkg::SIC_RECOVER && osc_tick && recover_done)) begin
      irq_take   <= 1'b1;
      irq_vector <= next_vector;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      clear_imask <= 1'b0;
    end else begin
      clear_imask <= (mode == sic_pkg::SIC_RUN) && (wait_exec || stop_exec);
    end
  end

  // Clock gating; the watchdog follows its disable bit only while in wait
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cpu_clk_en    <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_gate_en   <= 1'b1;
      watchdog_run  <= 1'b1;
    end else begin
      cpu_clk_en    <= (next_mode == sic_pkg::SIC_RUN) || any_reset;
      periph_clk_en <= next_mode != sic_pkg::SIC_STOP && next_mode != sic_pkg::SIC_RECOVER;
      osc_gate_en   <= next_mode != sic_pkg::SIC_STOP;
      watchdog_run  <= (next_mode == sic_pkg::SIC_WAIT) ? !watchdog_disable
                                                        : (next_mode == sic_pkg::SIC_RUN);
    end
  end

  // Break state lasts from the break request until the CPU acks the vector... and beyond,
  // until software leaves with the return; approximated here by the request level.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      in_break      <= 1'b0;
      break_protect <= 1'b0;
    end else begin
      in_break      <= break_req;
      break_protect <= break_req && !break_clear_enable;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      break_clear_enable <= sic_pkg::BREAK_CLEAR_ENABLE_RST;
    end else if (bus_req.wr && bus_req.addr == sic_pkg::ADDR_BREAK_FLAG_CTL) begin
      break_clear_enable <= bus_req.wdata[sic_pkg::BIT_BREAK_CLEAR_ENABLE];
    end
  end

  // Set on break leaving wait; set wins over a software write of zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      break_exited_wait_flag <= 1'b0;
    end else if (mode == sic_pkg::SIC_WAIT && break_req) begin
      break_exited_wait_flag <= 1'b1;
    end else if (bus_req.wr && bus_req.addr == sic_pkg::ADDR_BREAK_STATUS
                 && !bus_req.wdata[sic_pkg::BIT_BREAK_EXITED_WAIT]) begin
      break_exited_wait_flag <= 1'b0;
    end
  end

  // Reset cause flags; a new cause in the read cycle survives the clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reset_cause_status <= sic_pkg::RESET_CAUSE_AT_POWER_ON;
    end else if (reset_causes.power_on) begin
      reset_cause_status <= sic_pkg::RESET_CAUSE_AT_POWER_ON;
    end else begin
      for (int b = 0; b < 8; b++) begin
        if (bus_req.rd && bus_req.addr == sic_pkg::ADDR_RESET_CAUSE) begin
          reset_cause_status[b] <= 1'b0;
        end
      end
      if (reset_causes.pin) reset_cause_status[sic_pkg::BIT_RST_PIN] <= 1'b1;
      if (reset_causes.watchdog) reset_cause_status[sic_pkg::BIT_RST_WATCHDOG] <= 1'b1;
      if (reset_causes.bad_opcode) reset_cause_status[sic_pkg::BIT_RST_BAD_OPCODE] <= 1'b1;
      if (reset_causes.bad_fetch) reset_cause_status[sic_pkg::BIT_RST_BAD_FETCH] <= 1'b1;
      if (reset_causes.monitor_entry) begin
        reset_cause_status[sic_pkg::BIT_RST_MONITOR_ENTRY] <= 1'b1;
      end
      if (reset_causes.low_supply) reset_cause_status[sic_pkg::BIT_RST_LOW_SUPPLY] <= 1'b1;
    end
  end

  // Read data registered one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bus_rdata <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        sic_pkg::ADDR_BREAK_STATUS: begin
          bus_rdata <= {6'h00, break_exited_wait_flag, 1'b0};
        end
        sic_pkg::ADDR_RESET_CAUSE:      bus_rdata <= reset_cause_status;
        sic_pkg::ADDR_BREAK_FLAG_CTL:   bus_rdata <= {break_clear_enable, 7'h00};
        sic_pkg::ADDR_IRQ_STATUS_ONE:   bus_rdata <= {irq_req[6:1], 2'b00};
        sic_pkg::ADDR_IRQ_STATUS_TWO:   bus_rdata <= irq_req[14:7];
        sic_pkg::ADDR_IRQ_STATUS_THREE: bus_rdata <= {6'h00, irq_req[16:15]};
        default:                        bus_rdata <= 8'h00;
      endcase
    end
  end

  // Peripherals own their flags; they see break_protect and hold off both
  // steps of any clear while it is high, and a flag cleared stays cleared.
  // rely on that peripheral behaviour.

  property p_reset_read_clears;
    @(posedge clk) disable iff (!resetn)
      (bus_req.rd && bus_req.addr == sic_pkg::ADDR_RESET_CAUSE && !any_reset)
        |=> (reset_cause_status == 8'h00);
  endproperty
  a_reset_read_clears: assert property (p_reset_read_clears) else $error("cause not cleared");

  property p_power_on_only;
    @(posedge clk) disable iff (!resetn)
      reset_causes.power_on |=> (reset_cause_status == sic_pkg::RESET_CAUSE_AT_POWER_ON);
  endproperty
  a_power_on_only: assert property (p_power_on_only) else $error("power-on pattern wrong");

  property p_protect;
    @(posedge clk) disable iff (!resetn)
      (break_req && !break_clear_enable) |=> break_protect;
  endproperty
  a_protect: assert property (p_protect) else $error("break protect missing");

  property p_stop_gates;
    @(posedge clk) disable iff (!resetn || any_reset)
      (mode == sic_pkg::SIC_STOP && !wake_any) |=> !osc_gate_en && !periph_clk_en;
  endproperty
  a_stop_gates: assert property (p_stop_gates) else $error("clocks run in stop");

  property p_stop_count_clear;
    @(posedge clk) disable iff (!resetn)
      (mode == sic_pkg::SIC_STOP) |=> (stab_count == 12'h000);
  endproperty
  a_stop_count_clear: assert property (p_stop_count_clear) else $error("counter not held");

  property p_wait_break_flag;
    @(posedge clk) disable iff (!resetn || any_reset)
      (mode == sic_pkg::SIC_WAIT && break_req) |=> break_exited_wait_flag && irq_take;
  endproperty
  a_wait_break_flag: assert property (p_wait_break_flag) else $error("wait break flag");

  property p_imask_clear;
    @(posedge clk) disable iff (!resetn)
      (mode == sic_pkg::SIC_RUN && wait_exec && !any_reset) |=> clear_imask && !cpu_clk_en;
  endproperty
  a_imask_clear: assert property (p_imask_clear) else $error("wait entry wrong");

  property p_prio_first;
    @(posedge clk) disable iff (!resetn || any_reset)
      (!irq_take && mode == sic_pkg::SIC_RUN && instr_done && irq_req[1] && !cpu_imask
       && !swi_exec && !break_req) |=> (irq_vector == 5'h01);
  endproperty
  a_prio_first: assert property (p_prio_first) else $error("priority wrong");

  property p_irq_one_bits;
    @(posedge clk) disable iff (!resetn)
      (bus_req.rd && bus_req.addr == sic_pkg::ADDR_IRQ_STATUS_ONE)
        |=> (bus_rdata[1:0] == 2'b00) && (bus_rdata[7:2] == $past(irq_req[6:1]));
  endproperty
  a_irq_one_bits: assert property (p_irq_one_bits) else $error("status one wrong");

  property p_irq_two_bits;
    @(posedge clk) disable iff (!resetn)
      (bus_req.rd && bus_req.addr == sic_pkg::ADDR_IRQ_STATUS_TWO)
        |=> (bus_rdata == $past(irq_req[14:7]));
  endproperty
  a_irq_two_bits: assert property (p_irq_two_bits) else $error("status two wrong");

  property p_irq_three_bits;
    @(posedge clk) disable iff (!resetn)
      (bus_req.rd && bus_req.addr == sic_pkg::ADDR_IRQ_STATUS_THREE)
        |=> (bus_rdata[7:6] == 2'b00) && (bus_rdata[1:0] == $past(irq_req[16:15]));
  endproperty
  a_irq_three_bits: assert property (p_irq_three_bits) else $error("status three wrong");

  property p_wait_watchdog;
    @(posedge clk) disable iff (!resetn || any_reset)
      (mode == sic_pkg::SIC_WAIT && !wake_any && !watchdog_disable) |=> watchdog_run;
  endproperty
  a_wait_watchdog: assert property (p_wait_watchdog) else $error("watchdog halted in wait");

  // CPU and peripheral clocks come back on the same edge that hands the vector over
  property p_recover_exit;
    @(posedge clk) disable iff (!resetn || any_reset)
      (mode == sic_pkg::SIC_RECOVER && osc_tick && recover_done)
        |=> cpu_clk_en && periph_clk_en && osc_gate_en;
  endproperty
  a_recover_exit: assert property (p_recover_exit) else $error("recovery exit wrong");

endmodule : sic_core

`default_nettype wire

/* verilog/sic_pkg.sv */
package sic_pkg;

  // Register addresses on the CPU bus
  localparam logic [15:0] ADDR_BREAK_STATUS   = 16'hfe00;
  localparam logic [15:0] ADDR_RESET_CAUSE    = 16'hfe01;
  localparam logic [15:0] ADDR_BREAK_FLAG_CTL = 16'hfe03;
  // Interrupt status registers sit just above the break flag control register
  localparam logic [15:0] ADDR_IRQ_STATUS_ONE   = 16'hfe04;
  localparam logic [15:0] ADDR_IRQ_STATUS_TWO   = 16'hfe05;
  localparam logic [15:0] ADDR_IRQ_STATUS_THREE = 16'hfe06;

  // Field positions
  localparam int BIT_BREAK_EXITED_WAIT   = 1;
  localparam int BIT_BREAK_CLEAR_ENABLE  = 7;
  localparam int BIT_RST_POWER_ON        = 7;
  localparam int BIT_RST_PIN             = 6;
  localparam int BIT_RST_WATCHDOG        = 5;
  localparam int BIT_RST_BAD_OPCODE      = 4;
  localparam int BIT_RST_BAD_FETCH       = 3;
  localparam int BIT_RST_MONITOR_ENTRY   = 2;
  localparam int BIT_RST_LOW_SUPPLY      = 1;

  // Reset values
  localparam logic [7:0] RESET_CAUSE_AT_POWER_ON = 8'h80;
  localparam logic       BREAK_CLEAR_ENABLE_RST  = 1'b0;

  // Interrupt sources, flag 1 (external pin) highest to flag 16 (time base) lowest
  localparam int NUM_SOURCES = 16;
  localparam logic [4:0] VEC_NONE = 5'h00;
  localparam logic [4:0] VEC_SWI  = 5'h1f;

  // Stop recovery in oscillator clock cycles
  localparam int STOP_RECOVERY_LONG  = 4096;
  localparam int STOP_RECOVERY_SHORT = 32;
  localparam int STAB_COUNTER_WIDTH  = 12;
  localparam logic [11:0] STAB_LONG_LAST  = 12'(STOP_RECOVERY_LONG - 1);
  localparam logic [11:0] STAB_SHORT_LAST = 12'(STOP_RECOVERY_SHORT - 1);

  typedef enum logic [1:0] {
    SIC_RUN  = 2'b00,
    SIC_WAIT = 2'b01,
    SIC_STOP = 2'b10,
    SIC_RECOVER = 2'b11
  } sic_mode_t;

  // Reset causes reported for one cycle each
  typedef struct packed {
    logic power_on;
    logic pin;
    logic watchdog;
    logic bad_opcode;
    logic bad_fetch;
    logic monitor_entry;
    logic low_supply;
  } sic_reset_causes_t;

  // Byte-wide CPU register access
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } sic_bus_req_t;

endpackage : sic_pkg
